// >>> verilog/acs_regs.svh
// register map, field positions and reset values of the converter control
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ****************************************
// widths
// ****************************************
`define ACS_ADDR_W     4
`define ACS_DATA_W     8
`define ACS_RES_W      12
`define ACS_CH_W       5
`define ACS_IRQ_W      2

// ****************************************
// register offsets
// ****************************************
`define ACS_OFF_SC1    4'h0
`define ACS_OFF_SC2    4'h1
`define ACS_OFF_RESH   4'h2
`define ACS_OFF_RESL   4'h3
`define ACS_OFF_CVH    4'h4
`define ACS_OFF_CVL    4'h5
`define ACS_OFF_CFG    4'h6
`define ACS_OFF_ISTAT  4'h7
`define ACS_OFF_IMASK  4'h8

// ****************************************
// field positions
// ****************************************
`define ACS_SC1_DONE   7
`define ACS_SC1_IE     6
`define ACS_SC1_CONT   5
`define ACS_SC2_ACT    7
`define ACS_SC2_TRIG   6
`define ACS_SC2_CMPEN  5
`define ACS_SC2_GTE    4
`define ACS_CFG_MODE_H 3
`define ACS_CFG_MODE_L 2
`define ACS_IRQ_DONE   0
`define ACS_IRQ_LOST   1

// ****************************************
// reset values and codes
// ****************************************
`define ACS_SC1_RST    8'h1f
`define ACS_SC2_RST    8'h00
`define ACS_CFG_RST    8'h00
`define ACS_CH_OFF     5'h1f
`define ACS_CH_RSVD    5'h1c
`define ACS_CH_REFH    5'h1d
`define ACS_CH_REFL    5'h1e
`define ACS_MODE_8     2'h0
`define ACS_MODE_12    2'h1
`define ACS_MODE_10    2'h2

`endif

// >>> verilog/acs_pkg.sv
// types shared by the converter control block
`include "acs_regs.svh"
package acs_pkg;
    // one-hot controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } acs_state_t;

    // request to the analog core
    typedef struct packed {
        logic                   start;
        logic                   abort;
        logic                   power;
        logic [`ACS_CH_W-1:0]   channel;
        logic [1:0]             mode;
    } acs_core_req_t;

    // answer of the analog core
    typedef struct packed {
        logic                   done;
        logic [`ACS_RES_W-1:0]  result;
    } acs_core_rsp_t;
endpackage

// >>> verilog/acs_top.sv
// conversion control and status logic of the successive approximation converter
// ****************************************
// Overview of operation
// [R1] control write aborts and restarts conversion
// [R2] compare off: done flag every conversion
// [R3] compare on: flag only when true
// [R4] control write or low read clears flag
// [R5] done interrupt only while enable set
// [R6] single mode: one conversion per start
// [R7] continuous mode: back-to-back after start
// [R8] five-bit channel select field coding
// [R9] all-ones channel powers off, no extra
// [R10] single conversion end enters low power
// [R11] software writes zero to reserved bits
// [R12] active flag tracks conversion in progress
// [R13] trigger select: software or hardware
// [R14] compare enable bit gates compare
// [R15] direction: less-than or greater-equal
// [R16] mode field selects 8/12/10 bits
// [R17] high read locks result until low; the code does not lock in 8-bit mode
// [R18] compare stores result minus compare
// [R19] trigger synchronised, edge is one start
// ****************************************
`include "acs_regs.svh"
module acs_top
    import acs_pkg::*;
(
    input  wire logic                   CLK_I,
    input  wire logic                   ARST_N_I,
    input  wire logic [`ACS_ADDR_W-1:0] BUS_ADDR_I,
    input  wire logic [`ACS_DATA_W-1:0] BUS_WDATA_I,
    input  wire logic                   BUS_WR_I,
    input  wire logic                   BUS_RD_I,
    output logic      [`ACS_DATA_W-1:0] BUS_RDATA_O,
    input  wire logic                   HARDWARE_TRIGGER_IN_I,
    output acs_core_req_t               CORE_REQ_O,
    input  wire acs_core_rsp_t          CORE_RSP_I,
    output logic                        DONE_IRQ_O,
    output logic                        IRQ_O
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;     // first reset stage
    logic rst_n;            // released reset copy
    // reset enters asynchronously, leaves in step with the clock
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ****************************************
    // functions
    // ****************************************
    // keep only the bits that the mode produces
    function automatic logic [`ACS_RES_W-1:0] res_mask(
        input logic [1:0]            mode,
        input logic [`ACS_RES_W-1:0] v
    );
        logic [`ACS_RES_W-1:0] m;
        m = v;
        case (mode) // [R16]
            `ACS_MODE_8:  m = {4'h0, v[7:0]};
            `ACS_MODE_10: m = {2'h0, v[9:0]};
            `ACS_MODE_12: m = v;
            default:      m = v; // reserved code acts as 12 bits
        endcase
        return m;
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    logic                  done_flag_reg;  // conversion_done_flag
    logic                  irq_en_reg;     // done_irq_enable
    logic                  cont_reg;       // continuous_enable
    logic [`ACS_CH_W-1:0]  chan_reg;       // channel_select
    logic                  trig_hw_reg;    // trigger_select
    logic                  cmp_en_reg;     // compare_enable
    logic                  cmp_gte_reg;    // compare_greater_equal
    logic [3:0]            cvh_reg;        // compare value high
    logic [7:0]            cvl_reg;        // compare value low
    logic [`ACS_DATA_W-1:0] cfg_reg;       // configuration
    logic [`ACS_RES_W-1:0] result_reg;     // stored result
    logic                  lock_reg;       // high read interlock
    logic [`ACS_IRQ_W-1:0] istat_reg;      // sticky events
    logic [`ACS_IRQ_W-1:0] imask_reg;      // event mask
    acs_state_t            state_reg;      // controller state
    logic                  start_reg;      // start pulse out
    logic                  abort_reg;      // abort pulse out

    // ****************************************
    // bus decode
    // ****************************************
    logic wr_sc1;      // write to first control
    logic wr_sc2;      // write to second control
    logic rd_resh;     // read of result high
    logic rd_resl;     // read of result low
    logic [1:0] mode;  // resolution select
    assign wr_sc1  = BUS_WR_I && (BUS_ADDR_I == `ACS_OFF_SC1);
    assign wr_sc2  = BUS_WR_I && (BUS_ADDR_I == `ACS_OFF_SC2);
    assign rd_resh = BUS_RD_I && (BUS_ADDR_I == `ACS_OFF_RESH);
    assign rd_resl = BUS_RD_I && (BUS_ADDR_I == `ACS_OFF_RESL);
    assign mode    = cfg_reg[`ACS_CFG_MODE_H:`ACS_CFG_MODE_L];

    // ****************************************
    // hardware trigger synchroniser
    // ****************************************
    logic trig_s1_reg;   // metastable stage, seen only by s2
    logic trig_s2_reg;   // second stage
    logic trig_s3_reg;   // third stage
    logic trig_lvl_reg;  // agreed level
    logic trig_prv_reg;  // level one cycle ago
    logic hw_edge;       // new assertion
    // level only moves when two stages agree, filtering a glitch
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1_reg  <= 1'b0;
            trig_s2_reg  <= 1'b0;
            trig_s3_reg  <= 1'b0;
            trig_lvl_reg <= 1'b0;
            trig_prv_reg <= 1'b0;
        end else begin
            trig_s1_reg  <= HARDWARE_TRIGGER_IN_I;
            trig_s2_reg  <= trig_s1_reg;
            trig_s3_reg  <= trig_s2_reg;
            if (trig_s2_reg == trig_s3_reg) begin // [R19]
                trig_lvl_reg <= trig_s2_reg;
            end
            trig_prv_reg <= trig_lvl_reg;
        end
    end
    assign hw_edge = trig_lvl_reg && !trig_prv_reg; // [R19]
    // ****************************************
    // start and completion events
    // ****************************************
    logic        new_off;   // written channel is off code
    logic        sw_start;  // software start
    logic        hw_start;  // accepted hardware start
    logic        done_evt;  // conversion finished, not aborted
    logic        chain;     // continuous restart
    logic        start_now; // any start this cycle
    logic [`ACS_RES_W-1:0] res_m;   // masked result
    logic [`ACS_RES_W-1:0] cv_m;    // masked compare value
    logic [`ACS_RES_W-1:0] diff_m;  // result plus negated value
    logic        cmp_true;  // compare condition met
    logic        keep;      // result counts
    logic        flag_set;  // done flag rises
    logic        lost;      // result dropped by lock
    assign new_off  = (BUS_WDATA_I[`ACS_CH_W-1:0] == `ACS_CH_OFF); // [R9]
    // software trigger only starts when trigger select is zero
    assign sw_start = wr_sc1 && !new_off && !trig_hw_reg; // [R1] [R13]
    // hardware starts wait for idle; a trigger mid-conversion is dropped
    assign hw_start = hw_edge && trig_hw_reg && !wr_sc1 // [R13] [R19]
                   && (chan_reg != `ACS_CH_OFF)
                   && (state_reg == ST_IDLE);
    // a write in the finishing cycle wins: that result is discarded
    assign done_evt = (state_reg == ST_CONV) && CORE_RSP_I.done && !wr_sc1;
    assign chain    = done_evt && cont_reg; // [R7]
    assign start_now = sw_start || hw_start || chain;
    assign res_m    = res_mask(mode, CORE_RSP_I.result);
    assign cv_m     = res_mask(mode, {cvh_reg, cvl_reg});
    assign diff_m   = res_mask(mode, CORE_RSP_I.result + ~cv_m + 12'h001); // [R18]
    assign cmp_true = cmp_gte_reg ? (res_m >= cv_m) : (res_m < cv_m); // [R15]
    assign keep     = !cmp_en_reg || cmp_true; // [R14]
    assign flag_set = done_evt && keep; // [R2] [R3]
    assign lost     = flag_set && lock_reg;

    // ****************************************
    // controller state
    // ****************************************
    // state updates with the pulses to the core
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            start_reg <= start_now;
            // a write to the first control during a conversion stops the core
            abort_reg <= wr_sc1 && (state_reg == ST_CONV); // [R1]
            case (state_reg)
                ST_IDLE: begin
                    if (sw_start || hw_start) begin // [R6] [R13]
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (wr_sc1) begin
                        // off code ends without a further conversion
                        state_reg <= sw_start ? ST_CONV : ST_IDLE; // [R1] [R9]
                    end else if (done_evt && !chain) begin
                        state_reg <= ST_IDLE; // [R6] [R10]
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // first control: fields written as a whole byte
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= 1'(`ACS_SC1_RST >> `ACS_SC1_IE);
            cont_reg   <= 1'(`ACS_SC1_RST >> `ACS_SC1_CONT);
            chan_reg   <= 5'(`ACS_SC1_RST);
        end else if (wr_sc1) begin
            irq_en_reg <= BUS_WDATA_I[`ACS_SC1_IE];
            cont_reg   <= BUS_WDATA_I[`ACS_SC1_CONT];
            chan_reg   <= BUS_WDATA_I[`ACS_CH_W-1:0]; // [R8]
        end
    end
    // second control: low four bits are not stored
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            trig_hw_reg <= 1'(`ACS_SC2_RST >> `ACS_SC2_TRIG);
            cmp_en_reg  <= 1'(`ACS_SC2_RST >> `ACS_SC2_CMPEN);
            cmp_gte_reg <= 1'(`ACS_SC2_RST >> `ACS_SC2_GTE);
        end else if (wr_sc2) begin
            trig_hw_reg <= BUS_WDATA_I[`ACS_SC2_TRIG]; // [R13]
            cmp_en_reg  <= BUS_WDATA_I[`ACS_SC2_CMPEN]; // [R14]
            cmp_gte_reg <= BUS_WDATA_I[`ACS_SC2_GTE]; // [R15]
        end
    end
    // compare value and configuration
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cvh_reg <= 4'h0;
            cvl_reg <= 8'h00;
            cfg_reg <= `ACS_CFG_RST;
        end else if (BUS_WR_I) begin
            if (BUS_ADDR_I == `ACS_OFF_CVH) begin
                cvh_reg <= BUS_WDATA_I[3:0];
            end
            if (BUS_ADDR_I == `ACS_OFF_CVL) begin
                cvl_reg <= BUS_WDATA_I;
            end
            if (BUS_ADDR_I == `ACS_OFF_CFG) begin
                cfg_reg <= BUS_WDATA_I; // [R16]
            end
        end
    end

    // ****************************************
    // done flag, result and interlock
    // ****************************************
    // a rising flag beats a clearing low read in the same cycle
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            done_flag_reg <= 1'b0;
        end else if (flag_set) begin
            done_flag_reg <= 1'b1; // [R2] [R3]
        end else if (wr_sc1 || rd_resl) begin
            done_flag_reg <= 1'b0; // [R4]
        end
    end

    // result loads only when counted and not locked
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= '0;
        end else if (flag_set && !lock_reg) begin // [R17]
            result_reg <= cmp_en_reg ? diff_m : res_m; // [R18]
        end
    end

    // a high read outside 8-bit mode freezes the pair until the low byte is taken
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= 1'b0;
        end else if (rd_resh && (mode != `ACS_MODE_8)) begin
            lock_reg <= 1'b1; // [R17]
        end else if (rd_resl) begin
            lock_reg <= 1'b0; // [R17]
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    logic [`ACS_IRQ_W-1:0] ievt;  // events this cycle
    assign ievt[`ACS_IRQ_DONE] = flag_set && irq_en_reg; // [R5]
    assign ievt[`ACS_IRQ_LOST] = lost;
    // write one clears, but a new event in that cycle stays set
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            istat_reg <= '0;
            imask_reg <= '0;
        end else begin
            if (BUS_WR_I && (BUS_ADDR_I == `ACS_OFF_ISTAT)) begin
                istat_reg <= (istat_reg & ~BUS_WDATA_I[`ACS_IRQ_W-1:0]) | ievt;
            end else begin
                istat_reg <= istat_reg | ievt;
            end
            if (BUS_WR_I && (BUS_ADDR_I == `ACS_OFF_IMASK)) begin
                imask_reg <= BUS_WDATA_I[`ACS_IRQ_W-1:0];
            end
        end
    end
    assign DONE_IRQ_O = done_flag_reg && irq_en_reg; // [R5]
    assign IRQ_O      = |(istat_reg & imask_reg);

    // ****************************************
    // read port
    // ****************************************
    // data stand one cycle after the strobe; unmapped reads zero
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            BUS_RDATA_O <= '0;
        end else if (BUS_RD_I) begin
            case (BUS_ADDR_I)
                `ACS_OFF_SC1:   BUS_RDATA_O <= {done_flag_reg, irq_en_reg,
                                               cont_reg, chan_reg};
                // reserved low bits always read zero
                `ACS_OFF_SC2:   BUS_RDATA_O <= {state_reg == ST_CONV, // [R12]
                                               trig_hw_reg, cmp_en_reg,
                                               cmp_gte_reg, 4'h0};
                `ACS_OFF_RESH:  BUS_RDATA_O <= {4'h0, result_reg[11:8]};
                `ACS_OFF_RESL:  BUS_RDATA_O <= result_reg[7:0];
                `ACS_OFF_CVH:   BUS_RDATA_O <= {4'h0, cvh_reg};
                `ACS_OFF_CVL:   BUS_RDATA_O <= cvl_reg;
                `ACS_OFF_CFG:   BUS_RDATA_O <= cfg_reg;
                `ACS_OFF_ISTAT: BUS_RDATA_O <= {6'h00, istat_reg};
                `ACS_OFF_IMASK: BUS_RDATA_O <= {6'h00, imask_reg};
                default:        BUS_RDATA_O <= '0;
            endcase
        end else begin
            BUS_RDATA_O <= '0;
        end
    end

    // ****************************************
    // core request
    // ****************************************
    // core is powered only while converting
    always_comb begin
        CORE_REQ_O.start   = start_reg;
        CORE_REQ_O.abort   = abort_reg;
        CORE_REQ_O.power   = (state_reg == ST_CONV); // [R10] [R12]
        CORE_REQ_O.channel = chan_reg; // [R8]
        CORE_REQ_O.mode    = mode;
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);
    a_write_aborts: assert property ( // [R1]
        wr_sc1 && (state_reg == ST_CONV) |=> CORE_REQ_O.abort)
        else $error("control write did not abort");
    a_sw_restart: assert property ( // [R13]
        sw_start |=> CORE_REQ_O.start && CORE_REQ_O.power)
        else $error("software start not issued");
    a_off_no_extra: assert property ( // [R9]
        wr_sc1 && new_off |=> !CORE_REQ_O.start && !CORE_REQ_O.power)
        else $error("off code still converts");
    a_flag_plain: assert property ( // [R2]
        done_evt && !cmp_en_reg |=> done_flag_reg)
        else $error("done flag missing");
    a_flag_compare: assert property ( // [R3]
        done_evt && cmp_en_reg && !cmp_true && !done_flag_reg |=> !done_flag_reg)
        else $error("flag set on failed compare");
    a_flag_clears: assert property ( // [R4]
        (wr_sc1 || rd_resl) && !flag_set |=> !done_flag_reg)
        else $error("done flag not cleared");
    a_irq_follows: assert property ( // [R5]
        $rose(done_flag_reg) |-> DONE_IRQ_O == (irq_en_reg && istat_reg[`ACS_IRQ_DONE]))
        else $error("done interrupt wrong");
    a_single_sleep: assert property ( // [R10]
        done_evt && !cont_reg |=> !CORE_REQ_O.power ##1 (!CORE_REQ_O.power || CORE_REQ_O.start))
        else $error("single conversion stays powered");
    a_cont_chain: assert property ( // [R7]
        done_evt && cont_reg |=> CORE_REQ_O.start && CORE_REQ_O.power)
        else $error("continuous restart missing");
    a_lock_hold: assert property ( // [R17]
        lock_reg && flag_set |=> $stable(result_reg))
        else $error("locked result changed");
    a_hw_ignored: assert property ( // [R19]
        hw_edge && !trig_hw_reg && !wr_sc1 && (state_reg == ST_IDLE) |=> !CORE_REQ_O.start)
        else $error("trigger accepted in software mode");
    a_cmp_store: assert property ( // [R18]
        flag_set && cmp_en_reg && !lock_reg |=> result_reg == $past(diff_m))
        else $error("compare result stored wrong");
endmodule

// >>> dv/acs_tb.sv
// self-checking bench of the converter control block
`include "acs_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acs_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    `define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
        $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
    logic          clk;       // bus clock
    logic          arst_n;    // async reset, active low
    logic          wr;        // write strobe
    logic          rd;        // read strobe
    logic          hw;        // hardware trigger pin
    logic [3:0]    addr;      // register index
    logic [7:0]    wdata;     // write data
    logic [7:0]    rdata;     // read data
    acs_core_req_t req;       // request to the core
    acs_core_rsp_t rsp;       // core answer, driven here
    logic          done_irq;  // done interrupt
    logic          irq;       // masked status interrupt
    int            failures;  // mismatches
    int            cmp_count; // comparisons made
    int            starts;    // start pulses seen
    int            aborts;    // abort pulses seen
    acs_top u_dut (
        .CLK_I                 (clk),
        .ARST_N_I              (arst_n),
        .BUS_ADDR_I            (addr),
        .BUS_WDATA_I           (wdata),
        .BUS_WR_I              (wr),
        .BUS_RD_I              (rd),
        .BUS_RDATA_O           (rdata),
        .HARDWARE_TRIGGER_IN_I (hw),
        .CORE_REQ_O            (req),
        .CORE_RSP_I            (rsp),
        .DONE_IRQ_O            (done_irq),
        .IRQ_O                 (irq)
    );
    // ****************************************
    // clock and pulse counters
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count one-cycle core pulses so single versus continuous is visible
    always @(posedge clk) begin
        if (req.start === 1'b1) starts++;
        if (req.abort === 1'b1) aborts++;
    end
    // ****************************************
    // bus and core tasks
    // ****************************************
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    // one-cycle done pulse with its result, then let power settle
    task automatic core_done(input logic [11:0] r);
        @(posedge clk);
        rsp <= '{done: 1'b1, result: r};
        @(posedge clk);
        rsp.done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // bounded wait for the n-th start pulse
    task automatic wait_starts(input int n);
        for (int i = 0; i < 20 && starts < n; i++) @(posedge clk);
        if (starts < n) begin
            failures++;
            results();
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {arst_n, wr, rd, hw, addr, wdata} = '0;
        rsp = '0;
        failures = 0;
        cmp_count = 0;
        starts = 0;
        aborts = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`ACS_OFF_SC1, `ACS_SC1_RST);
        rd_chk(`ACS_OFF_SC2, 8'h00);
        `CHK(req.power, 1'b0)
        wr_reg(`ACS_OFF_CFG, 8'h04);
        // single software conversion with interrupt enabled
        wr_reg(`ACS_OFF_SC1, 8'h45);
        wait_starts(1);
        rd_chk(`ACS_OFF_SC2, 8'h80);
        `CHK(req.channel, 5'h05)
        `CHK(req.mode, 2'h1)
        core_done(12'h123);
        `CHK(req.power, 1'b0)
        rd_chk(`ACS_OFF_SC1, 8'hc5);
        `CHK(done_irq, 1'b1)
        rd_chk(`ACS_OFF_SC2, 8'h00);
        rd_chk(`ACS_OFF_RESH, 8'h01);
        rd_chk(`ACS_OFF_RESL, 8'h23);
        rd_chk(`ACS_OFF_SC1, 8'h45);
        `CHK(starts, 1)
        // status, mask and write-one-to-clear
        rd_chk(`ACS_OFF_ISTAT, 8'h01);
        `CHK(irq, 1'b0)
        wr_reg(`ACS_OFF_IMASK, 8'h01);
        #1 `CHK(irq, 1'b1)
        wr_reg(`ACS_OFF_ISTAT, 8'h01);
        #1 `CHK(irq, 1'b0)
        // interrupt enable off: flag sets, line stays low
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(2);
        core_done(12'h0ff);
        rd_chk(`ACS_OFF_SC1, 8'h85);
        `CHK(done_irq, 1'b0)
        // rewrite mid-conversion aborts and restarts
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(3);
        wr_reg(`ACS_OFF_SC1, 8'h06);
        wait_starts(4);
        `CHK(aborts, 1)
        rd_chk(`ACS_OFF_SC1, 8'h06);
        core_done(12'h010);
        // high read locks the result until the low read
        rd_chk(`ACS_OFF_RESH, 8'h00);
        wr_reg(`ACS_OFF_SC1, 8'h06);
        wait_starts(5);
        core_done(12'h3ab);
        rd_chk(`ACS_OFF_RESL, 8'h10);
        rd_chk(`ACS_OFF_ISTAT, 8'h02);
        // continuous run stopped by the all-ones channel
        wr_reg(`ACS_OFF_SC1, 8'h25);
        wait_starts(6);
        core_done(12'h001);
        wait_starts(7);
        wr_reg(`ACS_OFF_SC1, 8'h1f);
        repeat (4) @(posedge clk);
        #1 `CHK(req.power, 1'b0)
        `CHK(starts, 7)
        rd_chk(`ACS_OFF_SC2, 8'h00);
        // compare less-than against 0x100, then greater-or-equal
        wr_reg(`ACS_OFF_CVH, 8'h01);
        wr_reg(`ACS_OFF_CVL, 8'h00);
        wr_reg(`ACS_OFF_SC2, 8'h20);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(8);
        core_done(12'h200);
        rd_chk(`ACS_OFF_SC1, 8'h05);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(9);
        core_done(12'h050);
        rd_chk(`ACS_OFF_SC1, 8'h85);
        rd_chk(`ACS_OFF_RESH, 8'h0f);
        rd_chk(`ACS_OFF_RESL, 8'h50);
        wr_reg(`ACS_OFF_SC2, 8'h30);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(10);
        core_done(12'h100);
        rd_chk(`ACS_OFF_SC1, 8'h85);
        rd_chk(`ACS_OFF_RESH, 8'h00);
        rd_chk(`ACS_OFF_RESL, 8'h00);
        // hardware trigger: write arms only, pin edge is one start
        wr_reg(`ACS_OFF_SC2, 8'h40);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        repeat (4) @(posedge clk);
        `CHK(starts, 10)
        hw <= 1'b1;
        wait_starts(11);
        repeat (10) @(posedge clk);
        `CHK(starts, 11)
        hw <= 1'b0;
        core_done(12'h001);
        `CHK(req.power, 1'b0)
        // software trigger selected: a pin edge starts nothing
        wr_reg(`ACS_OFF_SC2, 8'h00);
        hw <= 1'b1;
        repeat (10) @(posedge clk);
        hw <= 1'b0;
        `CHK(starts, 11)
        // 8-bit: masked result and no interlock after a high read
        wr_reg(`ACS_OFF_CFG, 8'h00);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(12);
        core_done(12'habc);
        rd_chk(`ACS_OFF_RESH, 8'h00);
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(13);
        core_done(12'h0de);
        rd_chk(`ACS_OFF_RESL, 8'hde);
        // 10-bit keeps the low ten bits of the result
        wr_reg(`ACS_OFF_CFG, 8'h08);
        #1 `CHK(req.mode, 2'h2)
        wr_reg(`ACS_OFF_SC1, 8'h05);
        wait_starts(14);
        core_done(12'habc);
        rd_chk(`ACS_OFF_RESH, 8'h02);
        rd_chk(`ACS_OFF_RESL, 8'hbc);
        // unmapped index reads zero
        rd_chk(4'hf, 8'h00);
        results();
    end
endmodule
